// ==== verilog/sadc_defs.svh ====
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// ****************************************************************
// Conversion framing
// ****************************************************************
`define SADC_FRAME_BITS     16
`define SADC_TRACK_FALLS    4
`define SADC_CMD_BITS       8
`define SADC_RES_BITS       12
`define SADC_CHAN_MSB       5
`define SADC_CHAN_LSB       3

// ****************************************************************
// Timing
// ****************************************************************
`define SADC_SYS_CLK_NS     100
`define SADC_SCLK_PERIOD_NS 800
`define SADC_SCLK_HALF_CYC  ((`SADC_SCLK_PERIOD_NS / 2) / `SADC_SYS_CLK_NS)
`define SADC_SCLK_HALF_MIN  4

// ****************************************************************
// Controller registers (byte addresses) and fields
// ****************************************************************
`define SADC_REG_CMD        8'h00
`define SADC_REG_STATUS     8'h04
`define SADC_REG_RESULT     8'h08
`define SADC_CMD_CHAN_LSB   0
`define SADC_CMD_CNT_LSB    4
`define SADC_STAT_BUSY      0
`define SADC_STAT_VALID     1
`define SADC_RES_CHAN_LSB   16
`define SADC_RES_KNOWN_BIT  31
`define SADC_RESP_OKAY      2'h0
`define SADC_RESP_SLVERR    2'h2

`endif

// ==== verilog/sadc_pkg.sv ====
package sadc_pkg;

  typedef logic [2:0] sadc_chan_t;

  // Converter end sequencing states
  typedef enum logic [4:0] {
    SD_IDLE  = 5'h01,
    SD_ARM   = 5'h02,
    SD_TRACK = 5'h04,
    SD_CONV  = 5'h08,
    SD_PDN   = 5'h10
  } sadc_dev_state_e;

  // Controller end link states
  typedef enum logic [4:0] {
    SH_IDLE = 5'h01,
    SH_LEAD = 5'h02,
    SH_LOW  = 5'h04,
    SH_HIGH = 5'h08,
    SH_GAP  = 5'h10
  } sadc_host_state_e;

endpackage : sadc_pkg

// ==== verilog/sadc_link_if.sv ====
`timescale 1ns/1ps
interface sadc_link_if;
  logic cs_n;
  logic sclk;
  logic cmd;
  logic dout;
  logic dout_oe_n;
  // Released line reads as the inverse, so a sample taken too late shows as a wrong bit
  wire logic dout_line;
  assign dout_line = dout_oe_n ? ~dout : dout;

  modport dev  (input cs_n, input sclk, input cmd, output dout, output dout_oe_n);
  modport host (output cs_n, output sclk, output cmd, input dout_line);
endinterface : sadc_link_if

// ==== verilog/sadc_dev.sv ====
`timescale 1ns/1ps
`include "sadc_defs.svh"
// Overview of operation
// - Frame runs from select low to high
// - Host sends whole groups of sixteen rises
// - Result pin floats while select high
// - Clock ignored while select high
// - Track three cycles, convert twelve
// - Four leading zeros, then twelve bits MSB-first
// - Retrack after sixteenth rise; hold fourth fall
// - Select low, clock high: track next fall
// - Select low, clock low: fall counts first
// - Coincident falls start tracking at once
// - First eight rises shift command in
// - Loaded channel applies to next conversion
// - Host sends fresh command each conversion
// - First result after power-up from arbitrary channel
// - Host flags first result after power-up as channel unknown
// - Channel field bits five to three only
// - Channel code is plain binary index
// - Result is unsigned straight binary
// - Powered while select low, except gap
// - Conversions repeat while select stays low
module sadc_dev #(
  parameter int                 RES_W        = `SADC_RES_BITS,
  parameter sadc_pkg::sadc_chan_t POWERUP_CHAN = 3'h0
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  // Serial link
  sadc_link_if.dev              link,
  // Sampled input words, one per input
  input  wire logic [RES_W-1:0] analog_channel_0,
  input  wire logic [RES_W-1:0] analog_channel_1,
  input  wire logic [RES_W-1:0] analog_channel_2,
  input  wire logic [RES_W-1:0] analog_channel_3,
  input  wire logic [RES_W-1:0] analog_channel_4,
  input  wire logic [RES_W-1:0] analog_channel_5,
  input  wire logic [RES_W-1:0] analog_channel_6,
  input  wire logic [RES_W-1:0] analog_channel_7,
  // Status
  output sadc_pkg::sadc_chan_t  chan_sel,
  output logic                  tracking,
  output logic                  powered,
  output logic [RES_W-1:0]      result,
  output sadc_pkg::sadc_chan_t  result_chan,
  output logic                  result_valid
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  // Four leading zeros plus the result must fill one group exactly
  if (RES_W + `SADC_TRACK_FALLS != `SADC_FRAME_BITS) begin : g_bad_width
    $error("sadc_dev: RES_W must be 12");
  end

  // Channel field of the control word
  function automatic sadc_pkg::sadc_chan_t chan_of(input logic [7:0] w);
    return w[`SADC_CHAN_MSB:`SADC_CHAN_LSB];
  endfunction : chan_of

  // ****************************************************************
  // Input mux
  // ****************************************************************
  logic [RES_W-1:0] ain [8];

  // Plain binary index picks the input
  assign ain[0] = analog_channel_0;
  assign ain[1] = analog_channel_1;
  assign ain[2] = analog_channel_2;
  assign ain[3] = analog_channel_3;
  assign ain[4] = analog_channel_4;
  assign ain[5] = analog_channel_5;
  assign ain[6] = analog_channel_6;
  assign ain[7] = analog_channel_7;

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic cs_s1;
  logic cs_s2;
  logic cs_d;
  logic ck_s1;
  logic ck_s2;
  logic ck_d;
  logic cmd_s1;
  logic cmd_s2;

  // All three pins share the same depth so their relative timing holds
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_d   <= 1'b1;
      ck_s1  <= 1'b1;
      ck_s2  <= 1'b1;
      ck_d   <= 1'b1;
      cmd_s1 <= 1'b0;
      cmd_s2 <= 1'b0;
    end else begin
      cs_s1  <= link.cs_n;
      cs_s2  <= cs_s1;
      cs_d   <= cs_s2;
      ck_s1  <= link.sclk;
      ck_s2  <= ck_s1;
      ck_d   <= ck_s2;
      cmd_s1 <= link.cmd;
      cmd_s2 <= cmd_s1;
    end
  end

  logic cs_fall;
  logic fall_ev;
  logic rise_ev;

  // Clock edges only count inside a frame
  assign cs_fall = cs_d & ~cs_s2;
  assign fall_ev = ck_d & ~ck_s2 & ~cs_s2;
  assign rise_ev = ~ck_d & ck_s2 & ~cs_s2;

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  sadc_pkg::sadc_dev_state_e state;
  logic [4:0]                fall_cnt;
  logic [4:0]                rise_cnt;
  logic [4:0]                bit_idx;
  logic [RES_W-1:0]          hold_val;
  sadc_pkg::sadc_chan_t      hold_chan;
  logic [7:0]                cmd_sh;

  // Falls per group select phase and output bit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= sadc_pkg::SD_IDLE;
      fall_cnt <= 5'h00;
    end else if (cs_s2) begin
      state    <= sadc_pkg::SD_IDLE;
      fall_cnt <= 5'h00;
    end else if (cs_fall) begin
      if (ck_s2) begin
        state <= sadc_pkg::SD_ARM;
      end else begin
        // Clock already low or falling with select: counts as fall one
        state    <= sadc_pkg::SD_TRACK;
        fall_cnt <= 5'h01;
      end
    end else if (fall_ev) begin
      unique case (state)
        sadc_pkg::SD_ARM, sadc_pkg::SD_PDN: begin
          state    <= sadc_pkg::SD_TRACK;
          fall_cnt <= 5'h01;
        end
        sadc_pkg::SD_TRACK: begin
          fall_cnt <= fall_cnt + 5'h01;
          if (fall_cnt == 5'(`SADC_TRACK_FALLS - 1)) begin
            state <= sadc_pkg::SD_CONV;
          end
        end
        sadc_pkg::SD_CONV: begin
          fall_cnt <= fall_cnt + 5'h01;
          if (fall_cnt == 5'(`SADC_FRAME_BITS - 1)) begin
            state <= sadc_pkg::SD_PDN;
          end
        end
        sadc_pkg::SD_IDLE: begin
          state <= sadc_pkg::SD_IDLE;
        end
      endcase
    end
  end

  // Hold the selected input at the fall that ends tracking
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_val  <= '0;
      hold_chan <= 3'h0;
    end else if (fall_ev && state == sadc_pkg::SD_TRACK &&
                 fall_cnt == 5'(`SADC_TRACK_FALLS - 1)) begin
      hold_val  <= ain[chan_sel];
      hold_chan <= chan_sel;
    end
  end

  // ****************************************************************
  // Result shift-out
  // ****************************************************************
  // Fall five sends bit eleven, fall sixteen sends bit zero
  assign bit_idx = 5'(`SADC_FRAME_BITS - 1) - fall_cnt;

  // Launch on falls; zeros while tracking
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      link.dout <= 1'b0;
    end else if (cs_s2 || cs_fall) begin
      link.dout <= 1'b0;
    end else if (fall_ev) begin
      if (state == sadc_pkg::SD_CONV && fall_cnt < 5'(`SADC_FRAME_BITS)) begin
        link.dout <= hold_val[bit_idx[3:0]];
      end else begin
        link.dout <= 1'b0;
      end
    end
  end

  // Floats only after the synchronised select shows high
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      link.dout_oe_n <= 1'b1;
    end else begin
      link.dout_oe_n <= cs_s2;
    end
  end

  // Whole result is out at the sixteenth fall
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      result       <= '0;
      result_chan  <= 3'h0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (fall_ev && state == sadc_pkg::SD_CONV &&
          fall_cnt == 5'(`SADC_FRAME_BITS - 1)) begin
        result       <= hold_val;
        result_chan  <= hold_chan;
        result_valid <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Command capture
  // ****************************************************************
  // Rises per group: first eight shift the command, sixteenth closes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rise_cnt <= 5'h00;
      cmd_sh   <= 8'h00;
    end else if (cs_s2) begin
      rise_cnt <= 5'h00;
    end else if (rise_ev) begin
      if (rise_cnt < 5'(`SADC_CMD_BITS)) begin
        cmd_sh <= {cmd_sh[6:0], cmd_s2};
      end
      if (rise_cnt == 5'(`SADC_FRAME_BITS - 1)) begin
        rise_cnt <= 5'h00;
      end else begin
        rise_cnt <= rise_cnt + 5'h01;
      end
    end
  end

  // No command before power-up, so the first channel is a fixed guess
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_sel <= POWERUP_CHAN;
    end else if (rise_ev && rise_cnt == 5'(`SADC_FRAME_BITS - 1)) begin
      chan_sel <= chan_of(cmd_sh);
    end
  end

  // ****************************************************************
  // Power and phase status
  // ****************************************************************
  assign tracking = (state == sadc_pkg::SD_TRACK);
  assign powered  = (state == sadc_pkg::SD_ARM) ||
                    (state == sadc_pkg::SD_TRACK) ||
                    (state == sadc_pkg::SD_CONV);

endmodule : sadc_dev

// ==== verilog/sadc_host.sv ====
`timescale 1ns/1ps
`include "sadc_defs.svh"
module sadc_host #(
  parameter int SCLK_HALF = `SADC_SCLK_HALF_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial link
  sadc_link_if.host        link
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  // Shorter phases outrun the synchronisers on both ends
  if (SCLK_HALF < `SADC_SCLK_HALF_MIN || SCLK_HALF > 255) begin : g_bad_half
    $error("sadc_host: SCLK_HALF out of range");
  end

  // Register index: 0 cmd, 1 status, 2 result, 3 unmapped
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    unique case (a)
      `SADC_REG_CMD:    return 2'h0;
      `SADC_REG_STATUS: return 2'h1;
      `SADC_REG_RESULT: return 2'h2;
      default:          return 2'h3;
    endcase
  endfunction : reg_sel

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic       aw_got;
  logic       w_got;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic       w_lane0;
  logic       start;
  logic       busy;
  logic       res_valid;
  logic       rd_result;

  assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // Address and data are held separately, so either may come first
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      aw_addr      <= 8'h00;
      w_byte       <= 8'h00;
      w_lane0      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SADC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got   <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (aw_got && w_got) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (reg_sel(aw_addr) == 2'h3) ? `SADC_RESP_SLVERR : `SADC_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // A command write while a frame runs is dropped
  assign start = aw_got & w_got & w_lane0 & ~busy & (reg_sel(aw_addr) == 2'h0);

  assign rd_result = s_axi_arvalid & s_axi_arready & (reg_sel(s_axi_araddr) == 2'h2);

  // ****************************************************************
  // Link sequencer
  // ****************************************************************
  sadc_pkg::sadc_host_state_e state;
  logic [7:0]                 half_cnt;
  logic [3:0]                 rise_cnt;
  logic [3:0]                 conv_left;
  logic [7:0]                 cmd_word;
  logic [15:0]                rx_sh;
  logic [15:0]                rx_next;
  logic                       dl_s1;
  logic                       dl_s2;
  logic                       tick;
  logic                       grp_end;
  logic [11:0]                res_data;
  sadc_pkg::sadc_chan_t       cur_chan;
  sadc_pkg::sadc_chan_t       prev_chan;
  sadc_pkg::sadc_chan_t       res_chan;
  logic                       chan_known;
  logic                       res_known;

  assign busy    = (state != sadc_pkg::SH_IDLE);
  assign tick    = (half_cnt == 8'(SCLK_HALF - 1));
  assign rx_next = {rx_sh[14:0], dl_s2};
  assign grp_end = (state == sadc_pkg::SH_HIGH) && tick &&
                   (rise_cnt == 4'(`SADC_FRAME_BITS - 1));

  // Result pin synchroniser
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dl_s1 <= 1'b0;
      dl_s2 <= 1'b0;
    end else begin
      dl_s1 <= link.dout_line;
      dl_s2 <= dl_s1;
    end
  end

  // Divider for the serial clock phases
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      half_cnt <= 8'h00;
    end else if (start || tick || state == sadc_pkg::SH_IDLE) begin
      half_cnt <= 8'h00;
    end else begin
      half_cnt <= half_cnt + 8'h01;
    end
  end

  // Select falls with clock high; bits change on falls, sampled late high
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= sadc_pkg::SH_IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b1;
      link.cmd  <= 1'b0;
      rise_cnt  <= 4'h0;
      conv_left <= 4'h0;
      cmd_word  <= 8'h00;
      cur_chan  <= 3'h0;
      rx_sh     <= 16'h0000;
    end else begin
      unique case (state)
        sadc_pkg::SH_IDLE: begin
          if (start) begin
            state     <= sadc_pkg::SH_LEAD;
            link.cs_n <= 1'b0;
            cur_chan  <= w_byte[`SADC_CMD_CHAN_LSB +: 3];
            conv_left <= w_byte[`SADC_CMD_CNT_LSB +: 4];
            cmd_word  <= 8'({w_byte[`SADC_CMD_CHAN_LSB +: 3], 3'h0});
            rise_cnt  <= 4'h0;
          end
        end
        sadc_pkg::SH_LEAD, sadc_pkg::SH_HIGH: begin
          if (tick) begin
            if (state == sadc_pkg::SH_HIGH) begin
              rx_sh    <= rx_next;
              rise_cnt <= rise_cnt + 4'h1;
            end
            if (grp_end && conv_left == 4'h0) begin
              state     <= sadc_pkg::SH_GAP;
              link.cs_n <= 1'b1;
            end else begin
              state     <= sadc_pkg::SH_LOW;
              link.sclk <= 1'b0;
              if (grp_end) begin
                conv_left <= conv_left - 4'h1;
              end
              // Next rise index picks the command bit, zeros after eight
              if (state == sadc_pkg::SH_LEAD || grp_end) begin
                link.cmd <= cmd_word[7];
              end else if (rise_cnt < 4'(`SADC_CMD_BITS - 1)) begin
                link.cmd <= cmd_word[3'(6 - rise_cnt[2:0])];
              end else begin
                link.cmd <= 1'b0;
              end
            end
          end
        end
        sadc_pkg::SH_LOW: begin
          if (tick) begin
            state     <= sadc_pkg::SH_HIGH;
            link.sclk <= 1'b1;
          end
        end
        sadc_pkg::SH_GAP: begin
          if (tick) begin
            state <= sadc_pkg::SH_IDLE;
          end
        end
      endcase
    end
  end

  // Each result belongs to the channel commanded one conversion earlier
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      res_data   <= 12'h000;
      res_chan   <= 3'h0;
      res_known  <= 1'b0;
      prev_chan  <= 3'h0;
      chan_known <= 1'b0;
      res_valid  <= 1'b0;
    end else begin
      if (grp_end) begin
        res_data   <= rx_next[11:0];
        res_chan   <= prev_chan;
        res_known  <= chan_known;
        prev_chan  <= cur_chan;
        chan_known <= 1'b1;
      end
      // Setting wins over the clear by a result read
      if (grp_end) begin
        res_valid <= 1'b1;
      end else if (rd_result) begin
        res_valid <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SADC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `SADC_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      unique case (reg_sel(s_axi_araddr))
        2'h0: s_axi_rdata <= 32'({conv_left, 1'b0, cur_chan});
        2'h1: s_axi_rdata <= 32'({res_valid, busy});
        2'h2: s_axi_rdata <= {res_known, 12'h000, res_chan, 4'h0, res_data};
        2'h3: s_axi_rresp <= `SADC_RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : sadc_host

// ==== verif/sadc_link_sva.sv ====
`timescale 1ns/1ps
// ****
// Link watcher
// ****
module sadc_link_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic cmd,
  input wire logic dout,
  input wire logic dout_oe_n
);
  logic [4:0] fcnt;
  logic [3:0] rcnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Falls per group 1..16, cleared between frames
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) fcnt <= 5'h00;
    else if (cs_n) fcnt <= 5'h00;
    else if ($fell(sclk)) fcnt <= (fcnt == 5'h10) ? 5'h01 : fcnt + 5'h01;
  end
  // Rises modulo sixteen; wraps on purpose
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) rcnt <= 4'h0;
    else if (cs_n) rcnt <= 4'h0;
    else if ($rose(sclk)) rcnt <= rcnt + 4'h1;
  end
  // Margin of one cycle over the sync lag
  oe_float_a: assert property (cs_n [*5] |-> dout_oe_n)
    else $error("result pin driven while idle");
  oe_drive_a: assert property (!cs_n [*5] |-> !dout_oe_n)
    else $error("result pin floats in frame");
  lead_zero_a: assert property ($fell(sclk) && !cs_n && (fcnt < 5'h04 || fcnt == 5'h10)
    |-> ##4 !dout)
    else $error("leading bit not zero");
  group_whole_a: assert property ($rose(cs_n) |-> rcnt == 4'h0)
    else $error("partial group of rises");
  cmd_word_a: assert property ($rose(sclk) && !cs_n && !(rcnt inside {[4'h2:4'h4]})
    |-> !cmd)
    else $error("spare command bit set");
  sclk_idle_a: assert property (cs_n |-> sclk)
    else $error("clock moves outside frame");
  sclk_half_a: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
    else $error("clock low phase wrong");
  frame_lead_a: assert property ($fell(cs_n) |-> sclk [*4] ##1 !sclk)
    else $error("frame lead phase wrong");
endmodule : sadc_link_sva

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`include "sadc_defs.svh"
module tb;
  logic        sys_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [11:0] ana [8];
  logic [11:0] n;
  logic [2:0]  c, prev;
  int          fail_count, n_tests, i, k;
  int          n_rv, base;
  logic [11:0] d_res;
  logic [2:0]  d_chan, d_sel;
  logic        d_rv, d_trk, d_pwr;
  sadc_link_if lk ();
  sadc_dev #(.POWERUP_CHAN(3'h5)) i_sadc_dev (.sys_clk, .arst_n, .link(lk),
    .analog_channel_0(ana[0]), .analog_channel_1(ana[1]), .analog_channel_2(ana[2]),
    .analog_channel_3(ana[3]), .analog_channel_4(ana[4]), .analog_channel_5(ana[5]),
    .analog_channel_6(ana[6]), .analog_channel_7(ana[7]), .chan_sel(d_sel), .tracking(d_trk),
    .powered(d_pwr), .result(d_res), .result_chan(d_chan), .result_valid(d_rv));
  sadc_host i_sadc_host (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link(lk));
  sadc_link_sva i_sadc_link_sva (.sys_clk, .arst_n, .cs_n(lk.cs_n), .sclk(lk.sclk),
    .cmd(lk.cmd), .dout(lk.dout), .dout_oe_n(lk.dout_oe_n));
  // Device results seen, one pulse per conversion
  always @(posedge sys_clk) begin
    if (d_rv) n_rv++;
  end
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic logic [11:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[11:0];
  endfunction : xs
  // Known flag, channel field, data of that channel
  function automatic logic [31:0] exp_res(input logic [2:0] ch);
    return {1'b1, 12'h000, ch, 4'h0, ana[ch]};
  endfunction : exp_res
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic tmo();
    fail_count++;
    $display("ERROR wait exp done got timeout");
    wrap_up();
  endtask : tmo
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Starts one edge in, so no strobe is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    @(posedge sys_clk);
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int j = 0; j < 100 && !done; j++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) tmo();
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    logic done;
    @(posedge sys_clk);
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int j = 0; j < 100 && !done; j++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) tmo();
  endtask : rdr
  // Poll busy under a bound
  task automatic idle();
    rd = 32'h1;
    for (int j = 0; j < 500 && rd[0]; j++) rdr(`SADC_REG_STATUS);
    if (rd[0]) tmo();
  endtask : idle
  // Main sequence
  initial begin
    seed = 32'h0000D402;
    arst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    for (k = 0; k < 8; k++) ana[k] = xs();
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    chk("oe idle", 32'h1, {31'h0, lk.dout_oe_n});
    rdr(`SADC_REG_STATUS);
    chk("status", 32'h0, rd);
    rdr(8'h0C);
    chk("rresp", {30'h0, `SADC_RESP_SLVERR}, {30'h0, rs});
    wr(8'h10, 32'h0);
    chk("bresp", {30'h0, `SADC_RESP_SLVERR}, {30'h0, rs});
    prev = 3'(xs());
    wr(`SADC_REG_CMD, {29'h0, prev});
    idle();
    rdr(`SADC_REG_RESULT);
    chk("first known", 32'h0, {31'h0, rd[31]});
    chk("first data", {20'h0, ana[5]}, {20'h0, rd[11:0]});
    chk("dev first", {16'h0005, 4'h0, ana[5]}, {13'h0, d_chan, 4'h0, d_res});
    // Every code once, then random; frames of one to three conversions
    for (i = 0; i < 16; i++) begin
      for (k = 0; k < 8; k++) ana[k] <= xs();
      c = (i < 8) ? 3'(i) : 3'(xs());
      n = xs() % 12'h003;
      base = n_rv;
      wr(`SADC_REG_CMD, {24'h0, n[3:0], 1'b0, c});
      idle();
      rdr(`SADC_REG_RESULT);
      chk("result", exp_res((n == 12'h000) ? prev : c), rd);
      chk("dev result", exp_res((n == 12'h000) ? prev : c),
          {1'b1, 12'h000, d_chan, 4'h0, d_res});
      chk("conversions", {20'h0, n} + 32'h1, n_rv - base);
      chk("next chan", {29'h0, c}, {29'h0, d_sel});
      chk("powered", 32'h0, {30'h0, d_pwr, d_trk});
      rdr(`SADC_REG_STATUS);
      chk("valid clear", 32'h0, rd);
      prev = c;
    end
    wrap_up();
  end
endmodule : tb
